// >>> design/fpc_host.sv
`timescale 1ns/100ps
module fpc_host (
	input wire logic aclk, // system clock, 50 MHz
	input wire logic aresetn, // synchronous reset, active low
	input wire logic [7:0] s_axi_awaddr, // write address
	input wire logic s_axi_awvalid, // write address valid
	output logic s_axi_awready, // write address ready
	input wire logic [31:0] s_axi_wdata, // write data
	input wire logic [3:0] s_axi_wstrb, // write byte strobes
	input wire logic s_axi_wvalid, // write data valid
	output logic s_axi_wready, // write data ready
	output logic [1:0] s_axi_bresp, // write response
	output logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire logic [7:0] s_axi_araddr, // read address
	input wire logic s_axi_arvalid, // read address valid
	output logic s_axi_arready, // read address ready
	output logic [31:0] s_axi_rdata, // read data
	output logic [1:0] s_axi_rresp, // read response
	output logic s_axi_rvalid, // read data valid
	input wire logic s_axi_rready, // read data ready
	output logic [fpc_pkg::ADDR_W-1:0] flash_addr, // flash address
	output logic [7:0] flash_dq_o, // flash data out
	output logic flash_dq_oe, // high while driving data
	input wire logic [7:0] flash_dq_i, // flash data in (unused, reads are elsewhere)
	output logic flash_ce_n, // chip enable, active low
	output logic flash_we_n, // write enable, active low
	output logic flash_reset_n, // hardware reset, active low
	input wire logic ready_busy_n // device ready, low while busy
);
	import fpc_pkg::*;
	// ****************************************
	// registers and write sequence store
	// ****************************************
	logic [3:0] op_ff;
	logic [ADDR_W-1:0] tgt_addr_ff;
	logic [7:0] tgt_data_ff;
	logic bypass_ff;
	fpc_state_t state_ff, nxt_state;
	logic [2:0] step_ff, nxt_step;
	logic [7:0] cnt_ff, nxt_cnt;
	logic aw_hold_ff, w_hold_ff;
	logic [7:0] aw_addr_ff;
	logic [31:0] w_data_ff;
	logic [3:0] w_strb_ff;
	// ****************************************
	// sequence table: cycle count and per-step address/data
	// ****************************************
	wire busy = (state_ff != ST_IDLE);
	wire [10:0] seq_lo_addr[0:5];
	wire [7:0] seq_data[0:5];
	wire [2:0] seq_len;
	wire [5:0] seq_tgt; // step uses target address (PA or SA)
	wire is_prog = (op_ff == OP_PROGRAM);
	wire is_erase = (op_ff == OP_CHIP_ERASE) || (op_ff == OP_SECT_ERASE);
	// unlock prefix shared by program, bypass entry, autoselect and both erases [RL25]
	assign seq_lo_addr[0] = UNLOCK1_ADDR;
	assign seq_lo_addr[1] = UNLOCK2_ADDR;
	assign seq_lo_addr[2] = UNLOCK1_ADDR;
	assign seq_lo_addr[3] = UNLOCK1_ADDR;
	assign seq_lo_addr[4] = UNLOCK2_ADDR;
	assign seq_lo_addr[5] = UNLOCK1_ADDR;
	// two-write ops and single-write ops put their first command into slot 0; sector add is one
	// short write, so software can stack sectors well inside the accumulation window [RL15]
	wire short_op = (op_ff == OP_BYP_PROG) || (op_ff == OP_BYP_EXIT) || (op_ff == OP_SUSPEND)
		|| (op_ff == OP_RESUME) || (op_ff == OP_RESET_CMD) || (op_ff == OP_SECT_ADD);
	wire [7:0] cmd3 = is_prog ? CMD_PROGRAM : (op_ff == OP_BYP_ENTER) ? CMD_BYPASS :
		(op_ff == OP_AUTOSEL) ? CMD_AUTOSEL : CMD_ERASE_SETUP; // [RL1] [RL6] [RL10]
	wire [7:0] short0 = (op_ff == OP_BYP_PROG) ? CMD_PROGRAM : (op_ff == OP_BYP_EXIT) ? CMD_BYP_EXIT1 :
		(op_ff == OP_SUSPEND) ? CMD_SUSPEND : (op_ff == OP_RESUME) ? CMD_RESUME :
		(op_ff == OP_SECT_ADD) ? CMD_SECTOR_ERASE : CMD_RESET; // [RL7] [RL9] [RL18] [RL22]
	wire [7:0] short1 = (op_ff == OP_BYP_PROG) ? tgt_data_ff : CMD_BYP_EXIT2;
	assign seq_data[0] = short_op ? short0 : UNLOCK1_DATA;
	assign seq_data[1] = short_op ? short1 : UNLOCK2_DATA;
	assign seq_data[2] = cmd3;
	assign seq_data[3] = is_prog ? tgt_data_ff : UNLOCK1_DATA;
	assign seq_data[4] = UNLOCK2_DATA;
	assign seq_data[5] = (op_ff == OP_CHIP_ERASE) ? CMD_CHIP_ERASE : CMD_SECTOR_ERASE; // [RL13]
	assign seq_len = is_erase ? 3'd6 : is_prog ? 3'd4 : ((op_ff == OP_BYP_ENTER) || (op_ff == OP_AUTOSEL)) ? 3'd3 :
		((op_ff == OP_BYP_PROG) || (op_ff == OP_BYP_EXIT)) ? 3'd2 : 3'd1;
	// target-address slots: program's 4th, bypass program's 2nd, sector erase's 6th, sector add's 1st
	assign seq_tgt = {op_ff == OP_SECT_ERASE, 1'b0, is_prog, 1'b0, op_ff == OP_BYP_PROG, op_ff == OP_SECT_ADD};
	// unlock addresses only drive the low bits; upper bits held zero [RL24]
	wire [ADDR_W-1:0] step_addr = (seq_tgt[step_ff] || (short_op && op_ff != OP_SECT_ADD && step_ff == 3'd1 &&
		op_ff == OP_BYP_PROG)) ? tgt_addr_ff : {{(ADDR_W-11){1'b0}}, short_op ? 11'h000 : seq_lo_addr[step_ff]};
	wire last_step = (step_ff == seq_len - 3'd1);
	// ****************************************
	// write-cycle engine: each step is a CE/WE low pulse then a high gap
	// ****************************************
	always_comb begin
		nxt_state = state_ff;
		nxt_step = step_ff;
		nxt_cnt = (cnt_ff != 8'h00) ? cnt_ff - 8'h01 : 8'h00;
		unique case (state_ff)
			ST_IDLE: begin
				nxt_step = 3'd0;
			end
			ST_LOW: if (cnt_ff == 8'h00) begin
				nxt_state = ST_HIGH; // data taken on rising strobe [RL23]
				nxt_cnt = WE_HIGH_CYC - 8'h01; // the count includes zero, so load one less
			end
			ST_HIGH: if (cnt_ff == 8'h00) begin
				if (last_step) begin
					nxt_state = ST_IDLE;
				end else begin
					nxt_state = ST_LOW;
					nxt_step = step_ff + 3'd1;
					nxt_cnt = WE_LOW_CYC - 8'h01;
				end
			end
			ST_RST: if (cnt_ff == 8'h00) begin
				nxt_state = ST_IDLE; // aborts the device's operation [RL4]
			end
		endcase
	end
	// ****************************************
	// AXI4-Lite slave: address and data taken in either order
	// ****************************************
	wire aw_take = s_axi_awvalid && s_axi_awready;
	wire w_take = s_axi_wvalid && s_axi_wready;
	wire aw_have = aw_hold_ff || aw_take;
	wire w_have = w_hold_ff || w_take;
	wire [7:0] wa = aw_hold_ff ? aw_addr_ff : s_axi_awaddr;
	wire [31:0] wd = w_hold_ff ? w_data_ff : s_axi_wdata;
	wire [3:0] ws = w_hold_ff ? w_strb_ff : s_axi_wstrb;
	wire wr_fire = aw_have && w_have && !s_axi_bvalid;
	wire wr_ok = (wa == REG_CTRL) || (wa == REG_ADDR) || (wa == REG_DATA) || (wa == REG_STATUS);
	// a go while busy is dropped so an in-flight sequence is never torn apart
	wire go = wr_fire && (wa == REG_CTRL) && ws[1] && wd[CTRL_GO_BIT] && !busy;
	wire rd_ok = (s_axi_araddr == REG_CTRL) || (s_axi_araddr == REG_ADDR) || (s_axi_araddr == REG_DATA)
		|| (s_axi_araddr == REG_STATUS);
	wire [31:0] status_word = {29'h0, bypass_ff, ready_busy_n, busy};
	wire [31:0] rd_word = (s_axi_araddr == REG_CTRL) ? {28'h0, op_ff} :
		(s_axi_araddr == REG_ADDR) ? {{(32-ADDR_W){1'b0}}, tgt_addr_ff} :
		(s_axi_araddr == REG_DATA) ? {24'h0, tgt_data_ff} : (s_axi_araddr == REG_STATUS) ? status_word : 32'h0;
	// bus handshake flops
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_ff <= 1'b0;
			w_hold_ff <= 1'b0;
			aw_addr_ff <= 8'h00;
			w_data_ff <= 32'h0;
			w_strb_ff <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
		end else begin
			if (aw_take) begin
				aw_addr_ff <= s_axi_awaddr;
			end
			if (w_take) begin
				w_data_ff <= s_axi_wdata;
				w_strb_ff <= s_axi_wstrb;
			end
			aw_hold_ff <= aw_have && !wr_fire;
			w_hold_ff <= w_have && !wr_fire;
			s_axi_awready <= !aw_have && !s_axi_bvalid && !s_axi_awready;
			s_axi_wready <= !w_have && !s_axi_bvalid && !s_axi_wready;
			if (wr_fire) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end
	// read channel: data one cycle after the arvalid/arready handshake, held until rready
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= RESP_OKAY;
		end else begin
			s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_word;
				s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
	// ****************************************
	// order registers and engine state
	// ****************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			op_ff <= 4'h0;
			tgt_addr_ff <= '0;
			tgt_data_ff <= 8'h00;
			state_ff <= ST_IDLE;
			step_ff <= 3'd0;
			cnt_ff <= 8'h00;
		end else begin
			if (wr_fire && wa == REG_ADDR && !busy) begin
				tgt_addr_ff <= wd[ADDR_W-1:0];
			end
			if (wr_fire && wa == REG_DATA && ws[0] && !busy) begin
				tgt_data_ff <= wd[7:0];
			end
			if (go) begin
				op_ff <= wd[3:0];
				state_ff <= (wd[3:0] == OP_HW_RESET) ? ST_RST : ST_LOW;
				cnt_ff <= ((wd[3:0] == OP_HW_RESET) ? RESET_LOW_CYC : WE_LOW_CYC) - 8'h01;
				step_ff <= 3'd0;
			end else begin
				state_ff <= nxt_state;
				step_ff <= nxt_step;
				cnt_ff <= nxt_cnt;
			end
		end
	end
	// bypass mode tracking: set by entry, cleared by exit or hardware reset [RL8]
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bypass_ff <= 1'b0;
		end else if (state_ff == ST_HIGH && cnt_ff == 8'h00 && last_step) begin
			if (op_ff == OP_BYP_ENTER) begin
				bypass_ff <= 1'b1;
			end else if (op_ff == OP_BYP_EXIT) begin
				bypass_ff <= 1'b0;
			end
		end else if (state_ff == ST_RST) begin
			bypass_ff <= 1'b0;
		end
	end
	// ****************************************
	// flash pins, all from flops
	// ****************************************
	// strobes trail the state by one cycle, so address and data already belong to the new step
	// when the strobe falls; data is held one cycle past the rising strobe [RL23]
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flash_addr <= '0;
			flash_dq_o <= 8'h00;
			flash_dq_oe <= 1'b0;
			flash_ce_n <= 1'b1;
			flash_we_n <= 1'b1;
			flash_reset_n <= 1'b1;
		end else begin
			flash_addr <= step_addr;
			flash_dq_o <= seq_data[step_ff];
			flash_dq_oe <= (state_ff == ST_LOW) || !flash_we_n;
			flash_ce_n <= (state_ff != ST_LOW);
			flash_we_n <= (state_ff != ST_LOW);
			flash_reset_n <= (state_ff != ST_RST); // [RL4]
		end
	end
	// ****************************************
	// checks
	// ****************************************
	a_prog_four_cycles: assert property (@(posedge aclk) disable iff (!aresetn)
		go && wd[3:0] == OP_PROGRAM |=> seq_len == 3'd4) else $error("program not four writes"); // [RL1]
	a_erase_six_cycles: assert property (@(posedge aclk) disable iff (!aresetn)
		is_erase && busy |-> seq_len == 3'd6) else $error("erase not six writes"); // [RL10]
	a_bypass_entry: assert property (@(posedge aclk) disable iff (!aresetn)
		op_ff == OP_BYP_ENTER && !flash_we_n && step_ff == 3'd2 |-> flash_dq_o == CMD_BYPASS)
		else $error("bypass entry code wrong"); // [RL6]
	a_bypass_exit: assert property (@(posedge aclk) disable iff (!aresetn)
		op_ff == OP_BYP_EXIT && !flash_we_n |->
		flash_dq_o == ((step_ff == 3'd0) ? CMD_BYP_EXIT1 : CMD_BYP_EXIT2))
		else $error("bypass exit codes wrong"); // [RL9]
	a_sector_last: assert property (@(posedge aclk) disable iff (!aresetn)
		op_ff == OP_SECT_ERASE && !flash_we_n && step_ff == 3'd5 |->
		flash_addr == tgt_addr_ff && flash_dq_o == CMD_SECTOR_ERASE)
		else $error("sector erase last write wrong"); // [RL13]
	a_low_width: assert property (@(posedge aclk) disable iff (!aresetn)
		$fell(flash_we_n) |-> !flash_we_n [*3]) else $error("write pulse too short"); // [RL23]
	a_addr_stable: assert property (@(posedge aclk) disable iff (!aresetn)
		!flash_we_n && !$fell(flash_we_n) |-> $stable(flash_addr) && $stable(flash_dq_o))
		else $error("bus moved during write pulse"); // [RL23]
	a_reset_pulse: assert property (@(posedge aclk) disable iff (!aresetn)
		$fell(flash_reset_n) |-> flash_we_n && flash_ce_n) else $error("write during hardware reset"); // [RL4]
endmodule

// >>> design/fpc_pkg.sv
// Contract
// RL1: byte program is four writes: two unlocks, setup A0h, then address and data.
// RL2: device runs program alone and returns to array read when finished.
// RL3: device discards every command written while programming runs.
// RL4: hardware reset aborts program or erase; host reissues the sequence afterwards.
// RL5: programming only clears bits; only erase sets them back to one.
// RL6: unlock bypass entry is two unlocks then a write of 20h.
// RL7: bypass program is two writes: A0h then address and data, repeatable.
// RL8: in bypass mode only bypass program and bypass reset are accepted.
// RL9: bypass exit writes 90h then 00h, addresses ignored, back to array read.
// RL10: chip erase is six writes: unlocks, 80h, unlocks, then 10h.
// RL11: device preprograms cells itself before erasing; host never preprograms.
// RL12: device ignores every command during chip erase, suspend included.
// RL13: sector erase is the six-write pattern ending with sector address and 30h.
// RL14: device accumulates further sector erase pairs within 50 us of last strobe.
// RL15: host spaces extra sector erase commands less than 50 us apart.
// RL16: other commands in the window cancel the erase and return to array read. The model instead takes suspend as ending the window and suspending the erase.
// RL17: once sector erasure begins only erase suspend is accepted.
// RL18: suspend is ignored during chip erase or programming; address is don't-care.
// RL19: suspend during sector erase takes effect within 20 us.
// RL20: while suspended, reads and programs of unselected sectors are allowed.
// RL21: autoselect is accepted while suspended; leaving it returns to suspend.
// RL22: resume continues the suspended erase; repeated resumes are ignored.
// RL23: device takes address on later falling strobe and data on earlier rising one.
// RL24: upper address bits are don't-care in unlock and command cycles.
// RL25: unlocks AAh@555h, 55h@2AAh; 80h setup, 10h chip, 30h sector, B0h suspend, 30h resume.
// RL26: a mismatched write abandons the sequence and returns the device to array read.
package fpc_pkg;
	// ****************************************
	// flash bus and command codes
	// ****************************************
	localparam int ADDR_W = 21;
	localparam logic [10:0] UNLOCK1_ADDR = 11'h555;
	localparam logic [10:0] UNLOCK2_ADDR = 11'h2AA;
	localparam logic [7:0] UNLOCK1_DATA = 8'hAA;
	localparam logic [7:0] UNLOCK2_DATA = 8'h55;
	localparam logic [7:0] CMD_PROGRAM = 8'hA0;
	localparam logic [7:0] CMD_BYPASS = 8'h20;
	localparam logic [7:0] CMD_BYP_EXIT1 = 8'h90;
	localparam logic [7:0] CMD_BYP_EXIT2 = 8'h00;
	localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
	localparam logic [7:0] CMD_CHIP_ERASE = 8'h10;
	localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;
	localparam logic [7:0] CMD_SUSPEND = 8'hB0;
	localparam logic [7:0] CMD_RESUME = 8'h30;
	localparam logic [7:0] CMD_AUTOSEL = 8'h90;
	localparam logic [7:0] CMD_RESET = 8'hF0;
	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_MHZ = 50;
	localparam int WE_LOW_NS = 60;
	localparam int WE_HIGH_NS = 40;
	localparam int SECT_WIN_US = 50;
	localparam int RESET_LOW_NS = 500;
	localparam logic [7:0] WE_LOW_CYC = 8'((WE_LOW_NS * CLK_MHZ + 999) / 1000);
	localparam logic [7:0] WE_HIGH_CYC = 8'((WE_HIGH_NS * CLK_MHZ + 999) / 1000);
	localparam logic [7:0] RESET_LOW_CYC = 8'((RESET_LOW_NS * CLK_MHZ + 999) / 1000);
	localparam int SECT_WIN_CYC = SECT_WIN_US * CLK_MHZ;
	// ****************************************
	// register map (AXI4-Lite byte offsets)
	// ****************************************
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_ADDR = 8'h04;
	localparam logic [7:0] REG_DATA = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0C;
	localparam int CTRL_GO_BIT = 8;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_RDY_BIT = 1;
	localparam int STAT_BYP_BIT = 2;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	// operation codes written to ctrl[3:0]
	typedef enum logic [3:0] {
		OP_PROGRAM = 4'h1, OP_BYP_ENTER = 4'h2, OP_BYP_PROG = 4'h3, OP_BYP_EXIT = 4'h4,
		OP_CHIP_ERASE = 4'h5, OP_SECT_ERASE = 4'h6, OP_SECT_ADD = 4'h7, OP_SUSPEND = 4'h8,
		OP_RESUME = 4'h9, OP_AUTOSEL = 4'hA, OP_RESET_CMD = 4'hB, OP_HW_RESET = 4'hC
	} fpc_op_t;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00, ST_LOW = 2'b01, ST_HIGH = 2'b11, ST_RST = 2'b10
	} fpc_state_t;
endpackage

// >>> verification/fpc_flash_model.sv
`timescale 1ns/100ps
module fpc_flash_model import fpc_pkg::*; #(
	parameter int PROG_NS = 2000, // program busy time
	parameter int ERASE_NS = 8000 // erase busy time, short to keep runs brief
) (
	input wire logic [fpc_pkg::ADDR_W-1:0] addr, // address pins
	input wire logic [7:0] dq, // data line level
	input wire logic ce_n, // chip enable, active low
	input wire logic we_n, // write enable, active low
	input wire logic reset_n, // hardware reset, active low
	output logic ready_busy_n // low while an algorithm runs
);
	// ****************************************
	// behavioural command decoder
	// ****************************************
	localparam int S_RD = 0, S_U1 = 1, S_U2 = 2, S_PA = 3, S_BYP = 4, S_BA = 5, S_BX = 6;
	localparam int S_E1 = 7, S_E2 = 8, S_E3 = 9, S_WIN = 10, S_AS = 11, S_SUSP = 12;
	int st = 0;
	int busy = 0; // 1 program, 2 chip erase, 3 sector erase
	int home;
	logic susp = 1'b0;
	logic u1, u2;
	logic fell = 1'b0; // a falling strobe was seen, so the rising one closes a real write
	realtime end_t, win_t;
	logic [ADDR_W-1:0] la;
	logic [7:0] mem [256];
	logic [28:0] wlog [$]; // every write seen, read by the bench
	wire wr_n = we_n | ce_n;
	assign ready_busy_n = (busy == 0) || susp;
	// address on the later falling strobe, data on the earlier rising one
	always @(negedge wr_n) begin
		la = addr;
		fell = 1'b1;
	end
	// the first strobe level out of an unknown start is not a write
	always @(posedge wr_n) if (reset_n && fell) begin
		fell = 1'b0;
		home = susp ? S_SUSP : S_RD;
		u1 = la[10:0] == UNLOCK1_ADDR; // upper bits ignored
		u2 = la[10:0] == UNLOCK2_ADDR && dq == UNLOCK2_DATA;
		wlog.push_back({la, dq});
		// a running algorithm drops writes; only a sector erase listens for suspend
		if (busy != 0 && !susp) begin
			if (busy == 3 && dq == CMD_SUSPEND) begin
				susp = 1'b1;
				st = S_SUSP;
			end
		end else case (st)
			S_RD, S_SUSP: if (u1 && dq == UNLOCK1_DATA) st = S_U1;
				else if (susp && dq == CMD_RESUME) begin // repeats fall into the busy branch
					susp = 1'b0;
					end_t = $realtime + ERASE_NS;
				end
			S_U1: st = u2 ? S_U2 : home;
			S_U2: if (!u1) st = home;
				else if (dq == CMD_PROGRAM) st = S_PA;
				else if (dq == CMD_AUTOSEL) st = S_AS;
				else if (dq == CMD_BYPASS && !susp) st = S_BYP;
				else if (dq == CMD_ERASE_SETUP && !susp) st = S_E1;
				else st = home;
			S_PA, S_BA: begin
				mem[la[7:0]] = mem[la[7:0]] & dq; // programming only clears bits
				if (!susp) busy = 1;
				end_t = $realtime + PROG_NS;
				st = (st == S_BA) ? S_BYP : home;
			end
			S_BYP: st = (dq == CMD_PROGRAM) ? S_BA : (dq == CMD_BYP_EXIT1) ? S_BX : S_BYP;
			S_BX: st = (dq == CMD_BYP_EXIT2) ? S_RD : S_BYP;
			S_E1: st = (u1 && dq == UNLOCK1_DATA) ? S_E2 : S_RD;
			S_E2: st = u2 ? S_E3 : S_RD;
			S_E3: if (u1 && dq == CMD_CHIP_ERASE) begin // no preprogram needed from outside
					mem = '{default: 8'hFF};
					busy = 2;
					end_t = $realtime + ERASE_NS;
					st = S_RD;
				end else if (dq == CMD_SECTOR_ERASE) begin
					st = S_WIN;
					win_t = $realtime + SECT_WIN_US * 1000;
				end else st = S_RD;
			S_WIN: if (dq == CMD_SECTOR_ERASE) win_t = $realtime + SECT_WIN_US * 1000;
				else if (dq == CMD_SUSPEND) begin // window ends at once
					busy = 3;
					susp = 1'b1;
					st = S_SUSP;
				end else st = S_RD;
			S_AS: st = (dq == CMD_RESET) ? home : S_AS;
			default: st = home;
		endcase
	end
	// self-timed algorithms; a 100 ns grain is fine enough for the bench
	always #100 begin
		if (busy != 0 && !susp && $realtime >= end_t) begin // back to array read (bypass mode after a bypass program), address dropped
			if (busy != 1) st = S_RD;
			busy = 0;
		end
		if (st == S_WIN && $realtime >= win_t) begin // window over, erasure starts
			busy = 3;
			end_t = $realtime + ERASE_NS;
			st = S_RD;
		end
	end
	// hardware reset aborts whatever runs
	always @(negedge reset_n) begin
		busy = 0;
		susp = 1'b0;
		st = S_RD;
	end
endmodule

// >>> verification/tb.sv
`timescale 1ns/100ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_fail++; $display("ERROR %0t: got %0h want %0h", $time, g, e); end end
module tb;
	import fpc_pkg::*;
	// ****************************************
	// bench for the flash command controller
	// ****************************************
	localparam logic [20:0] A1 = 21'(UNLOCK1_ADDR);
	logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
	logic s_axi_bready = 1'b1, s_axi_rready = 1'b1; // held high: the bench always takes answers
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, flash_dq_oe;
	logic flash_ce_n, flash_we_n, flash_reset_n, ready_busy_n;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic [20:0] flash_addr;
	logic [7:0] flash_dq_o;
	wire logic [7:0] dq_line = flash_dq_oe ? flash_dq_o : ~flash_dq_o; // released line never keeps its value
	int n_fail = 0, checks = 0, cyc = 0, lo = 0, rl = 0;
	integer seed;
	logic [30:0] exp_q [$];
	fpc_host u_fpc_host (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .flash_addr,
		.flash_dq_o, .flash_dq_oe, .flash_dq_i(dq_line), .flash_ce_n, .flash_we_n, .flash_reset_n, .ready_busy_n);
	fpc_flash_model u_fpc_flash_model (.addr(flash_addr), .dq(dq_line), .ce_n(flash_ce_n), .we_n(flash_we_n),
		.reset_n(flash_reset_n), .ready_busy_n);
	always #10 aclk = ~aclk;
	// strobe shape and reset pulse length, watched every cycle
	always @(posedge aclk) if (aresetn) begin
		if (!flash_we_n) lo++;
		else if (lo != 0) begin
			`CHK(lo, int'(WE_LOW_CYC))
			lo = 0;
		end
		`CHK(flash_ce_n, flash_we_n)
		if (!flash_we_n) `CHK(flash_dq_oe, 1'b1)
		if (!flash_reset_n) rl++;
		else if (rl != 0) begin
			`CHK(rl, int'(RESET_LOW_CYC))
			rl = 0;
		end
	end
	// a hang costs a mismatch rather than a stuck run
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 30000) begin
			n_fail++;
			conclude();
		end
	end
	task automatic conclude();
		$display("checks %0d mismatches %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic tend(input string s);
		$display("test %s done", s);
	endtask
	// bus cycles; each starts just after a rising edge
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
	endtask
	task automatic stat(output logic [31:0] v);
		logic [1:0] r;
		rd(REG_STATUS, v, r);
	endtask
	task automatic wait_bit(input int b, input logic val);
		logic [31:0] v;
		do stat(v); while (v[b] !== val);
	endtask
	// expected flash writes: kind 0 address free, 1 low bits only, 2 full address
	task automatic push(input logic [1:0] k, input logic [20:0] a, input logic [7:0] d);
		exp_q.push_back({k, a, d});
	endtask
	task automatic unl(input logic [1:0] k, input logic [20:0] a, input logic [7:0] d);
		push(2'd1, A1, UNLOCK1_DATA);
		push(2'd1, 21'(UNLOCK2_ADDR), UNLOCK2_DATA);
		push(k, a, d);
	endtask
	task automatic build(input fpc_op_t op, input logic [20:0] a, input logic [7:0] d);
		case (op)
			OP_PROGRAM: begin unl(2'd1, A1, CMD_PROGRAM); push(2'd2, a, d); end
			OP_BYP_ENTER: unl(2'd1, A1, CMD_BYPASS);
			OP_BYP_PROG: begin push(2'd0, 21'h0, CMD_PROGRAM); push(2'd2, a, d); end
			OP_BYP_EXIT: begin push(2'd0, 21'h0, CMD_BYP_EXIT1); push(2'd0, 21'h0, CMD_BYP_EXIT2); end
			OP_CHIP_ERASE: begin unl(2'd1, A1, CMD_ERASE_SETUP); unl(2'd1, A1, CMD_CHIP_ERASE); end
			OP_SECT_ERASE: begin unl(2'd1, A1, CMD_ERASE_SETUP); unl(2'd2, a, CMD_SECTOR_ERASE); end
			OP_SECT_ADD: push(2'd2, a, CMD_SECTOR_ERASE);
			OP_SUSPEND: push(2'd0, 21'h0, CMD_SUSPEND);
			OP_RESUME: push(2'd0, 21'h0, CMD_RESUME);
			OP_AUTOSEL: unl(2'd1, A1, CMD_AUTOSEL);
			OP_RESET_CMD: push(2'd0, 21'h0, CMD_RESET);
			default: ;
		endcase
	endtask
	task automatic cmp_log();
		logic [30:0] e;
		logic [28:0] g;
		`CHK(u_fpc_flash_model.wlog.size(), exp_q.size())
		while (exp_q.size() != 0 && u_fpc_flash_model.wlog.size() != 0) begin
			e = exp_q.pop_front();
			g = u_fpc_flash_model.wlog.pop_front();
			`CHK(g[7:0], e[7:0])
			if (e[30:29] == 2'd1) `CHK(g[18:8], e[18:8])
			if (e[30:29] == 2'd2) `CHK(g[28:8], e[28:8])
		end
		exp_q.delete();
		u_fpc_flash_model.wlog.delete();
	endtask
	// one operation with random address and data; dbl repeats go while busy
	task automatic run(input fpc_op_t op, input bit dbl);
		logic [20:0] a;
		logic [7:0] d;
		logic [1:0] r;
		logic [31:0] c;
		a = 21'($random(seed));
		d = 8'($random(seed));
		c = 32'(op) | (32'h1 << CTRL_GO_BIT);
		wr(REG_ADDR, 32'(a), r);
		wr(REG_DATA, 32'(d), r);
		build(op, a, d);
		wr(REG_CTRL, c, r);
		if (dbl) wr(REG_CTRL, c, r);
		wait_bit(STAT_BUSY_BIT, 1'b0);
		cmp_log();
	endtask
	initial begin
		logic [31:0] v;
		logic [1:0] r;
		seed = 32'h3a06;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		stat(v);
		`CHK(v[2:0], 3'b010)
		rd(8'h10, v, r);
		`CHK(r, RESP_SLVERR)
		`CHK(v, 32'h0)
		wr(8'h14, 32'h1, r);
		`CHK(r, RESP_SLVERR)
		tend("registers");
		repeat (3) begin
			run(OP_PROGRAM, 1'b1);
			stat(v);
			`CHK(v[STAT_RDY_BIT], 1'b0)
			wait_bit(STAT_RDY_BIT, 1'b1);
		end
		tend("program");
		run(OP_BYP_ENTER, 1'b0);
		stat(v);
		`CHK(v[STAT_BYP_BIT], 1'b1)
		repeat (2) begin
			run(OP_BYP_PROG, 1'b0);
			wait_bit(STAT_RDY_BIT, 1'b1);
		end
		run(OP_BYP_EXIT, 1'b0);
		stat(v);
		`CHK(v[STAT_BYP_BIT], 1'b0)
		tend("bypass");
		run(OP_CHIP_ERASE, 1'b0);
		run(OP_SUSPEND, 1'b0);
		stat(v);
		`CHK(v[STAT_RDY_BIT], 1'b0)
		run(OP_HW_RESET, 1'b0);
		stat(v);
		`CHK(v[STAT_RDY_BIT], 1'b1)
		run(OP_CHIP_ERASE, 1'b0); // reissued after the abort
		wait_bit(STAT_RDY_BIT, 1'b1);
		tend("chip erase");
		run(OP_SECT_ERASE, 1'b0);
		run(OP_SECT_ADD, 1'b0); // far inside the window
		run(OP_SUSPEND, 1'b0);
		stat(v);
		`CHK(v[STAT_RDY_BIT], 1'b1)
		run(OP_AUTOSEL, 1'b0);
		run(OP_RESET_CMD, 1'b0);
		run(OP_RESUME, 1'b0);
		stat(v);
		`CHK(v[STAT_RDY_BIT], 1'b0)
		run(OP_RESUME, 1'b0);
		run(OP_SUSPEND, 1'b0);
		stat(v);
		`CHK(v[STAT_RDY_BIT], 1'b1)
		run(OP_RESUME, 1'b0);
		wait_bit(STAT_RDY_BIT, 1'b1);
		tend("sector erase");
		conclude();
	end
endmodule
